// ===== design/hyst_cmp.v
// Hysteresis comparator of one quantity against a threshold pair
`include "relay_sel_map.vh"
module hyst_cmp #(
	parameter W = `THR_W
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Quantity and thresholds
	input wire [W-1:0] value,
	input wire [W-1:0] upper,
	input wire [W-1:0] lower,
	// Held comparison
	output reg above
);
	always @(posedge clk) begin
		if (!nrst) begin
			above <= 1'b0;
		end else if (value > upper) begin
			above <= 1'b1;
		end else if (value < lower) begin
			above <= 1'b0;
		end
	end
endmodule

// ===== design/relay_sel_map.vh
// Constants for the relay status output selector
// Summary of operation
// - Setting 0: relay active while drive enabled and running.
// - Setting 1: relay active while powered and no fault exists.
// - Limit settings: set above upper threshold, clear below lower threshold.
// - Function select picks one condition; active closes NO, opens NC.
// - Setting 2: relay active while output frequency equals set-point.
// - Setting 3: relay active while output frequency above zero.
// - Setting 4: speed above limit, with shared hysteresis thresholds.
// - Setting 5: current above limit, with shared hysteresis thresholds.
// - Setting 6: torque above limit, with shared thresholds.
// - Setting 7: second analog input above limit.
// - Setting 8 reserved: relay held inactive.
// - Setting 9: relay active while emergency override mode runs.
// - Setting 10: relay active once maintenance timer expired.
// - Setting 11: relay active in auto mode while no trip is present.
// - Setting 12: relay active while drive is tripped.
// - Setting 13: relay active when both hardware enables present.
// - Setting 14: PID error above limit, with shared thresholds.
// - Setting 15: relay active when load monitoring flags high load.
// - Upper threshold ranges lower threshold to 200 percent, default 100.
// - Lower threshold ranges zero to upper threshold, default 0.
// - One threshold pair serves analog output and relay selectors.
`ifndef RELAY_SEL_MAP_VH
`define RELAY_SEL_MAP_VH
`define FN_RUNNING 4'h0
`define FN_HEALTHY 4'h1
`define FN_AT_SPEED 4'h2
`define FN_FREQ_NZ 4'h3
`define FN_FREQ_LIM 4'h4
`define FN_CURR_LIM 4'h5
`define FN_TORQ_LIM 4'h6
`define FN_AIN2_LIM 4'h7
`define FN_RESERVED 4'h8
`define FN_OVERRIDE 4'h9
`define FN_MAINT 4'hA
`define FN_AVAILABLE 4'hB
`define FN_TRIPPED 4'hC
`define FN_HW_ENABLE 4'hD
`define FN_PID_LIM 4'hE
`define FN_HIGH_LOAD 4'hF
`define FN_RESET 4'h1
`define THR_W 11
`define THR_MAX 11'h7D0
`define UPPER_RESET 11'h3E8
`define LOWER_RESET 11'h000
`endif

// ===== design/relay_status_output_select.v
// Relay status output selector with shared hysteresis thresholds
`include "relay_sel_map.vh"
module relay_status_output_select #(
	parameter W = `THR_W
) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Configuration
	input wire [3:0] relay_function_select,
	input wire [W-1:0] upper_threshold,
	input wire [W-1:0] lower_threshold,
	// Drive status
	input wire drive_running,
	input wire power_present,
	input wire fault_present,
	input wire at_target_freq,
	input wire freq_nonzero,
	input wire override_active,
	input wire maint_expired,
	input wire auto_mode,
	input wire trip_present,
	input wire tripped_state,
	input wire [1:0] hardware_enable_inputs,
	input wire load_mon_enabled,
	input wire high_load,
	// Scaled quantities, tenths of a percent
	input wire [W-1:0] speed_pct,
	input wire [W-1:0] current_pct,
	input wire [W-1:0] torque_pct,
	input wire [W-1:0] ain2_pct,
	input wire [W-1:0] pid_error_pct,
	// Thresholds as applied, shared with analog output
	output reg [W-1:0] upper_eff,
	output reg [W-1:0] lower_eff,
	// Relay contacts
	output reg first_relay_output,
	output wire relay_no_closed,
	output wire relay_nc_closed
);
	reg [W-1:0] up_d;
	reg [W-1:0] lo_d;
	reg sel_d;
	wire [4:0] lim;
	wire [W*5-1:0] qty;

	// Threshold clamping to legal ranges
	always @* begin
		up_d = upper_threshold;
		if (up_d > `THR_MAX) begin
			up_d = `THR_MAX;
		end
		lo_d = lower_threshold;
		if (lo_d > up_d) begin
			lo_d = up_d;
		end
	end

	always @(posedge clk) begin
		if (!nrst) begin
			upper_eff <= `UPPER_RESET;
			lower_eff <= `LOWER_RESET;
		end else begin
			upper_eff <= up_d;
			lower_eff <= lo_d;
		end
	end

	assign qty = {pid_error_pct, ain2_pct, torque_pct, current_pct,
		speed_pct};

	// One comparator per limit quantity
	genvar i;
	generate
		for (i = 0; i < 5; i = i + 1) begin : g_cmp
			hyst_cmp #(.W(W)) u_cmp (
				.clk(clk),
				.nrst(nrst),
				.value(qty[i*W +: W]),
				.upper(upper_eff),
				.lower(lower_eff),
				.above(lim[i])
			);
		end
	endgenerate

	// Function selection
	always @* begin
		case (relay_function_select)
		`FN_RUNNING: sel_d = drive_running;
		`FN_HEALTHY: sel_d = power_present & ~fault_present;
		`FN_AT_SPEED: sel_d = at_target_freq;
		`FN_FREQ_NZ: sel_d = freq_nonzero;
		`FN_FREQ_LIM: sel_d = lim[0];
		`FN_CURR_LIM: sel_d = lim[1];
		`FN_TORQ_LIM: sel_d = lim[2];
		`FN_AIN2_LIM: sel_d = lim[3];
		`FN_RESERVED: sel_d = 1'b0;
		`FN_OVERRIDE: sel_d = override_active;
		`FN_MAINT: sel_d = maint_expired;
		`FN_AVAILABLE: sel_d = auto_mode & ~trip_present;
		`FN_TRIPPED: sel_d = tripped_state;
		`FN_HW_ENABLE: sel_d = &hardware_enable_inputs;
		`FN_PID_LIM: sel_d = lim[4];
		`FN_HIGH_LOAD: sel_d = load_mon_enabled & high_load;
		default: sel_d = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (!nrst) begin
			first_relay_output <= 1'b0;
		end else begin
			first_relay_output <= sel_d;
		end
	end

	assign relay_no_closed = first_relay_output;
	assign relay_nc_closed = ~first_relay_output;
endmodule

// ===== dv/relay_chk.sv
// Assertion checker for the relay selector
module relay_chk #(parameter W = 11) (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// Observed
	input wire [3:0] relay_function_select,
	input wire drive_running,
	input wire maint_expired,
	input wire override_active,
	input wire tripped_state,
	input wire [1:0] hardware_enable_inputs,
	input wire [W-1:0] upper_eff,
	input wire [W-1:0] lower_eff,
	input wire first_relay_output,
	input wire relay_nc_closed
);
	timeunit 1ns / 1ns;
	reg [4:0] h_q;
	wire r = first_relay_output;
	always @(posedge clk) h_q <= {nrst, relay_function_select};
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_run_follow: assert property (
		h_q == 5'h10 |-> r == $past(drive_running)) else $error("run");
	a_maint_due: assert property (
		h_q == 5'h1A |-> r == $past(maint_expired)) else $error("maint");
	a_override_on: assert property (
		h_q == 5'h19 |-> r == $past(override_active)) else $error("ovr");
	a_trip_show: assert property (
		h_q == 5'h1C |-> r == $past(tripped_state)) else $error("trip");
	a_hw_enable: assert property (
		h_q == 5'h1D |-> r == &$past(hardware_enable_inputs)) else $error("hw");
	a_reserved_off: assert property (
		h_q == 5'h18 |-> !r) else $error("reserved");
	a_nc_inverse: assert property (
		relay_nc_closed == !r) else $error("nc");
	a_thr_order: assert property (
		lower_eff <= upper_eff && upper_eff <= 11'h7D0) else $error("thr");
endmodule
bind relay_status_output_select relay_chk #(.W(W)) chk (.*);

// ===== dv/relay_contact.sv
// Relay contact pair seen from the plant wiring
module relay_contact (
	// Coil side
	input wire no_closed,
	input wire nc_closed,
	// Terminal links
	output wire link_no,
	output wire link_nc
);
	timeunit 1ns / 1ns;
	assign link_no = no_closed;
	assign link_nc = nc_closed & ~no_closed;
endmodule

// ===== dv/tb.sv
// Random bench for the relay selector
module tb;
	timeunit 1ns / 1ns;
	logic clk = 0, nrst = 0, rel, no_c, nc_c, lk_no, lk_nc, e_q;
	logic [3:0] fs = 0;
	logic [13:0] b = 0;
	logic [4:0] ab;
	logic [10:0] up = 0, lo = 0, ue, le, me, ml, cu;
	logic [10:0] v [5] = '{default: 11'h0};
	integer seed = 32'hBDEC, bad_count = 0, checked = 0, i, n;
	relay_status_output_select uut (.clk(clk), .nrst(nrst),
		.relay_function_select(fs), .upper_threshold(up),
		.lower_threshold(lo), .drive_running(b[0]), .power_present(b[1]),
		.fault_present(b[2]), .at_target_freq(b[3]), .freq_nonzero(b[4]),
		.override_active(b[5]), .maint_expired(b[6]), .auto_mode(b[7]),
		.trip_present(b[8]), .tripped_state(b[9]),
		.hardware_enable_inputs(b[11:10]), .load_mon_enabled(b[12]),
		.high_load(b[13]), .speed_pct(v[0]), .current_pct(v[1]),
		.torque_pct(v[2]), .ain2_pct(v[3]), .pid_error_pct(v[4]),
		.upper_eff(ue), .lower_eff(le), .first_relay_output(rel),
		.relay_no_closed(no_c), .relay_nc_closed(nc_c));
	relay_contact far (.no_closed(no_c), .nc_closed(nc_c),
		.link_no(lk_no), .link_nc(lk_nc));
	assign cu = up > 11'h7D0 ? 11'h7D0 : up;
	function automatic logic f_exp(input logic [3:0] f,
		input logic [13:0] s, input logic [4:0] a);
		logic [15:0] c;
		c = {s[13] & s[12], a[4], &s[11:10], s[9], s[7] & ~s[8], s[6], s[5],
			1'b0, a[3:0], s[4], s[3], s[1] & ~s[2], s[0]};
		return c[f];
	endfunction
	task cmp(input logic [10:0] g, input logic [10:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		if (!nrst) begin
			ab <= 5'h00;
			e_q <= 1'b0;
			me <= 11'h3E8;
			ml <= 11'h000;
		end else begin
			me <= cu;
			ml <= lo > cu ? cu : lo;
			for (i = 0; i < 5; i++)
				if (v[i] > me)
					ab[i] <= 1'b1;
				else if (v[i] < ml)
					ab[i] <= 1'b0;
			e_q <= f_exp(fs, b, ab);
		end
	end
	initial begin
		for (n = 0; n < 6000; n++) begin
			@(negedge clk);
			cmp(rel, e_q);
			cmp(ue, me);
			cmp(le, ml);
			cmp({lk_no, lk_nc}, {e_q, !e_q});
			nrst = n >= 8 && (n < 3000 || n > 3004);
			b = $random(seed);
			v[n % 5] = $random(seed);
			if (n % 16 == 0)
				fs = $random(seed);
			if (n % 300 == 0)
				{up, lo} = n == 0 ? 22'h3FFFFF : $random(seed);
		end
		summarize;
	end
endmodule
